// >>> hdl/cosdo_map.vh
// Constants for the fieldbus master-side sync, emergency and service-data controller
`ifndef COSDO_MAP_VH
`define COSDO_MAP_VH

// ----------------------------------------------------------------
// Software register offsets
// ----------------------------------------------------------------
`define COSDO_REG_CTRL      4'h0
`define COSDO_REG_NODE      4'h1
`define COSDO_REG_WIN       4'h2
`define COSDO_REG_OVF       4'h3
`define COSDO_REG_SDOIDX    4'h4
`define COSDO_REG_SDODATA   4'h5
`define COSDO_REG_SDOLEN    4'h6
`define COSDO_REG_STATUS    4'h7
`define COSDO_REG_SDORESP   4'h8
`define COSDO_REG_EMCY      4'h9
`define COSDO_REG_ABORT     4'hA
`define COSDO_REG_SYNCCNT   4'hB

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define COSDO_CTRL_SYNC_GO  0
`define COSDO_CTRL_SDO_GO   1
`define COSDO_CTRL_EN       2
`define COSDO_CTRL_CNT_EN   3

// ----------------------------------------------------------------
// Identifiers
// ----------------------------------------------------------------
`define COSDO_ID_SYNC       11'h080
`define COSDO_ID_EMCY       11'h080
`define COSDO_ID_SDO_REQ    11'h600
`define COSDO_ID_SDO_RSP    11'h580

// ----------------------------------------------------------------
// Service-data command bytes
// ----------------------------------------------------------------
`define COSDO_CMD_DL1       8'h2F
`define COSDO_CMD_DL2       8'h2B
`define COSDO_CMD_DL3       8'h27
`define COSDO_CMD_DL4       8'h23
`define COSDO_CMD_DL_OK     8'h60
`define COSDO_CMD_ABORT     8'h80

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define COSDO_RST_WIN       16'h0000
`define COSDO_RST_OVF       8'h00
`define COSDO_CLK_MHZ       25
`define COSDO_US_CYCLES     5'd25
`define COSDO_RSP_TMO_US    16'd1000

`endif

// >>> hdl/cosdo_us_tick.v
// Microsecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
`include "cosdo_map.vh"

module cosdo_us_tick (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Tick out
    output wire        us_tick
);
    reg [4:0] cnt_ff;

    assign us_tick = (cnt_ff == `COSDO_US_CYCLES - 5'd1);

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 5'h00;
        end else if (us_tick) begin
            cnt_ff <= 5'h00;
        end else begin
            cnt_ff <= cnt_ff + 5'd1;
        end
    end
endmodule // cosdo_us_tick

`default_nettype wire

// >>> hdl/cosdo_sdo_fmt.v
// Expedited download frame builder and response decoder
`timescale 1ns/1ps
`default_nettype none
`include "cosdo_map.vh"

module cosdo_sdo_fmt (
    // Request fields
    input  wire [15:0] obj_index,
    input  wire [7:0]  obj_sub,
    input  wire [31:0] obj_data,
    input  wire [2:0]  obj_len,
    // Built request
    output reg  [63:0] req_frame,
    output wire        len_ok,
    // Response decode
    input  wire [63:0] rsp_frame,
    output wire        rsp_ok,
    output wire        rsp_abort,
    output wire        rsp_match,
    output wire [31:0] rsp_code
);
    reg [7:0] cmd;

    // Length to command byte; byte 0 first, index low byte at byte 1
    always @* begin
        case (obj_len)
            3'd1:    cmd = `COSDO_CMD_DL1;
            3'd2:    cmd = `COSDO_CMD_DL2;
            3'd3:    cmd = `COSDO_CMD_DL3;
            3'd4:    cmd = `COSDO_CMD_DL4;
            default: cmd = 8'h00;
        endcase
        req_frame = {cmd, obj_index[7:0], obj_index[15:8], obj_sub,
                     obj_data[7:0], obj_data[15:8], obj_data[23:16], obj_data[31:24]};
    end

    assign len_ok    = (cmd != 8'h00);
    assign rsp_ok    = (rsp_frame[63:56] == `COSDO_CMD_DL_OK);
    assign rsp_abort = (rsp_frame[63:56] == `COSDO_CMD_ABORT);
    assign rsp_match = (rsp_frame[55:48] == obj_index[7:0]) &&
                       (rsp_frame[47:40] == obj_index[15:8]) &&
                       (rsp_frame[39:32] == obj_sub);
    assign rsp_code  = {rsp_frame[7:0], rsp_frame[15:8], rsp_frame[23:16], rsp_frame[31:24]};
endmodule // cosdo_sdo_fmt

`default_nettype wire

// >>> hdl/cosdo_master.v
// Master-side controller: sync production, window timing, expedited downloads, emergency intake
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cosdo_map.vh"

module cosdo_master (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Software register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Frame transmit
    output wire        tx_valid,
    input  wire        tx_ready,
    output reg  [10:0] tx_id,
    output reg  [3:0]  tx_dlc,
    output reg  [63:0] tx_data,
    // Frame receive
    input  wire        rx_valid,
    input  wire [10:0] rx_id,
    input  wire [63:0] rx_data,
    // Window status
    output wire        sync_window
);
    // ------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SYNC = 4'b0010;
    localparam [3:0] ST_SDO  = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [3:0]  state_ff;
    reg        en_ff;
    reg        cnt_en_ff;
    reg [6:0]  node_ff;
    reg [15:0] win_us_ff;
    reg [7:0]  ovf_ff;
    reg [7:0]  sync_cnt_ff;
    reg [15:0] win_left_ff;
    reg [15:0] idx_ff;
    reg [7:0]  sub_ff;
    reg [31:0] data_ff;
    reg [2:0]  len_ff;
    reg        sync_req_ff;
    reg        sdo_req_ff;
    reg        sdo_busy_ff;
    reg        sdo_done_ff;
    reg        sdo_err_ff;
    reg        sdo_tmo_ff;
    reg        len_bad_ff;
    reg        emcy_seen_ff;
    reg [31:0] emcy_info_ff;
    reg [31:0] abort_ff;
    reg [15:0] tmo_ff;

    wire       us_tick;
    wire [63:0] req_frame;
    wire       len_ok;
    wire       rsp_ok;
    wire       rsp_abort;
    wire       rsp_match;
    wire [31:0] rsp_code;

    function [10:0] plus_node;
        input [10:0] base;
        input [6:0]  node;
        begin
            plus_node = base + {4'h0, node};
        end
    endfunction

    function wr_hit;
        input [3:0] a;
        input [3:0] off;
        begin
            wr_hit = reg_wr && (a == off);
        end
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    cosdo_us_tick u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .us_tick (us_tick)
    );

    cosdo_sdo_fmt u_fmt (
        .obj_index (idx_ff),
        .obj_sub   (sub_ff),
        .obj_data  (data_ff),
        .obj_len   (len_ff),
        .req_frame (req_frame),
        .len_ok    (len_ok),
        .rsp_frame (rx_data),
        .rsp_ok    (rsp_ok),
        .rsp_abort (rsp_abort),
        .rsp_match (rsp_match),
        .rsp_code  (rsp_code)
    );

    // ------------------------------------------------------------
    // Window and receive decode
    // ------------------------------------------------------------
    assign sync_window = (win_left_ff != 16'h0000);
    assign tx_valid    = (state_ff == ST_SYNC) || (state_ff == ST_SDO);

    wire rsp_hit  = rx_valid && (rx_id == plus_node(`COSDO_ID_SDO_RSP, node_ff));
    wire emcy_hit = rx_valid && (rx_id > `COSDO_ID_EMCY) &&
                    (rx_id <= `COSDO_ID_EMCY + 11'h07F);
    // Service data waits for window close
    wire sdo_can  = sdo_req_ff && !sync_window && !sync_req_ff;
    wire sync_go  = wr_hit(reg_addr, `COSDO_REG_CTRL) && reg_wdata[`COSDO_CTRL_SYNC_GO];
    wire [7:0] cnt_inc = sync_cnt_ff + 8'd1;
    wire [7:0] cnt_nxt = (sync_cnt_ff >= ovf_ff) ? 8'd1 : cnt_inc;

    // ------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= ST_IDLE;
            en_ff        <= 1'b0;
            cnt_en_ff    <= 1'b0;
            node_ff      <= 7'h01;
            win_us_ff    <= `COSDO_RST_WIN;
            ovf_ff       <= `COSDO_RST_OVF;
            sync_cnt_ff  <= 8'h00;
            win_left_ff  <= 16'h0000;
            idx_ff       <= 16'h0000;
            sub_ff       <= 8'h00;
            data_ff      <= 32'h00000000;
            len_ff       <= 3'd0;
            sync_req_ff  <= 1'b0;
            sdo_req_ff   <= 1'b0;
            sdo_busy_ff  <= 1'b0;
            sdo_done_ff  <= 1'b0;
            sdo_err_ff   <= 1'b0;
            sdo_tmo_ff   <= 1'b0;
            len_bad_ff   <= 1'b0;
            emcy_seen_ff <= 1'b0;
            emcy_info_ff <= 32'h00000000;
            abort_ff     <= 32'h00000000;
            tmo_ff       <= 16'h0000;
            tx_id        <= 11'h000;
            tx_dlc       <= 4'h0;
            tx_data      <= 64'h0;
        end else begin
            // Register writes
            if (wr_hit(reg_addr, `COSDO_REG_CTRL)) begin
                en_ff     <= reg_wdata[`COSDO_CTRL_EN];
                cnt_en_ff <= reg_wdata[`COSDO_CTRL_CNT_EN];
                if (reg_wdata[`COSDO_CTRL_SYNC_GO]) begin
                    sync_req_ff <= 1'b1;
                end
                if (reg_wdata[`COSDO_CTRL_SDO_GO] && !sdo_busy_ff) begin
                    if (len_ok) begin
                        sdo_req_ff  <= 1'b1;
                        sdo_busy_ff <= 1'b1;
                        sdo_done_ff <= 1'b0;
                        sdo_err_ff  <= 1'b0;
                        sdo_tmo_ff  <= 1'b0;
                        len_bad_ff  <= 1'b0;
                    end else begin
                        len_bad_ff <= 1'b1;
                    end
                end
            end
            if (wr_hit(reg_addr, `COSDO_REG_NODE)) begin
                node_ff <= reg_wdata[6:0];
            end
            if (wr_hit(reg_addr, `COSDO_REG_WIN)) begin
                win_us_ff <= reg_wdata[15:0];
            end
            if (wr_hit(reg_addr, `COSDO_REG_OVF)) begin
                ovf_ff <= reg_wdata[7:0];
            end
            if (wr_hit(reg_addr, `COSDO_REG_SDOIDX) && !sdo_busy_ff) begin
                idx_ff <= reg_wdata[15:0];
                sub_ff <= reg_wdata[23:16];
            end
            if (wr_hit(reg_addr, `COSDO_REG_SDODATA) && !sdo_busy_ff) begin
                data_ff <= reg_wdata;
            end
            if (wr_hit(reg_addr, `COSDO_REG_SDOLEN) && !sdo_busy_ff) begin
                len_ff <= reg_wdata[2:0];
            end

            // Window countdown
            if (win_left_ff != 16'h0000 && us_tick) begin
                win_left_ff <= win_left_ff - 16'd1;
            end

            // Emergency capture; read of the register clears, set wins
            if (reg_rd && reg_addr == `COSDO_REG_EMCY) begin
                emcy_seen_ff <= 1'b0;
            end
            if (emcy_hit) begin
                emcy_seen_ff <= 1'b1;
                emcy_info_ff <= {rx_id[7:0], rx_data[63:48], rx_data[47:40]};
            end

            case (state_ff)
                ST_IDLE: begin
                    if (en_ff && sync_req_ff) begin
                        tx_id   <= `COSDO_ID_SYNC;
                        if (cnt_en_ff && ovf_ff > 8'd1) begin
                            tx_dlc  <= 4'd1;
                            tx_data <= {cnt_nxt, 56'h0};
                        end else begin
                            tx_dlc  <= 4'd0;
                            tx_data <= 64'h0;
                        end
                        state_ff <= ST_SYNC;
                    end else if (en_ff && sdo_can) begin
                        tx_id    <= plus_node(`COSDO_ID_SDO_REQ, node_ff);
                        tx_dlc   <= 4'd8;
                        tx_data  <= req_frame;
                        state_ff <= ST_SDO;
                    end else if (sdo_busy_ff && !sdo_req_ff) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_SYNC: begin
                    if (tx_ready) begin
                        sync_req_ff <= sync_go;
                        win_left_ff <= win_us_ff;
                        if (cnt_en_ff && ovf_ff > 8'd1) begin
                            sync_cnt_ff <= cnt_nxt;
                        end
                        state_ff <= sdo_busy_ff && !sdo_req_ff ? ST_WAIT : ST_IDLE;
                    end
                end
                ST_SDO: begin
                    if (tx_ready) begin
                        sdo_req_ff <= 1'b0;
                        tmo_ff     <= `COSDO_RSP_TMO_US;
                        state_ff   <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rsp_hit && rsp_match && rsp_ok) begin
                        sdo_busy_ff <= 1'b0;
                        sdo_done_ff <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end else if (rsp_hit && rsp_match && rsp_abort) begin
                        abort_ff    <= rsp_code;
                        sdo_busy_ff <= 1'b0;
                        sdo_err_ff  <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end else if (tmo_ff == 16'h0000) begin
                        sdo_busy_ff <= 1'b0;
                        sdo_tmo_ff  <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end else if (en_ff && sync_req_ff) begin
                        state_ff <= ST_IDLE;
                    end else if (us_tick) begin
                        tmo_ff <= tmo_ff - 16'd1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `COSDO_REG_CTRL:    reg_rdata <= {28'h0, cnt_en_ff, en_ff, 2'b00};
                `COSDO_REG_NODE:    reg_rdata <= {25'h0, node_ff};
                `COSDO_REG_WIN:     reg_rdata <= {16'h0, win_us_ff};
                `COSDO_REG_OVF:     reg_rdata <= {24'h0, ovf_ff};
                `COSDO_REG_SDOIDX:  reg_rdata <= {8'h0, sub_ff, idx_ff};
                `COSDO_REG_SDODATA: reg_rdata <= data_ff;
                `COSDO_REG_SDOLEN:  reg_rdata <= {29'h0, len_ff};
                `COSDO_REG_STATUS:  reg_rdata <= {24'h0, emcy_seen_ff, len_bad_ff, sdo_tmo_ff,
                                                  sdo_err_ff, sdo_done_ff, sdo_busy_ff,
                                                  sync_window, sync_req_ff};
                `COSDO_REG_SDORESP: reg_rdata <= {16'h0, win_left_ff};
                `COSDO_REG_EMCY:    reg_rdata <= emcy_info_ff;
                `COSDO_REG_ABORT:   reg_rdata <= abort_ff;
                `COSDO_REG_SYNCCNT: reg_rdata <= {24'h0, sync_cnt_ff};
                default:            reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // cosdo_master

`default_nettype wire

// >>> dv/cosdo_master_asserts.sv
// Port checker for the master-side sync and service-data controller
`timescale 1ns/1ps
`default_nettype none
module cosdo_master_asserts (
    // Clock, reset and register port
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Frame link
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [3:0]  tx_dlc,
    input wire logic [63:0] tx_data,
    input wire logic        rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic [63:0] rx_data,
    input wire logic        sync_window
);
    logic [7:0] cmd;
    logic       sdo;
    assign cmd = tx_data[63:56];
    assign sdo = tx_valid && tx_id[10:7] == 4'hC;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_sync_take;
        tx_valid && tx_ready && tx_id == 11'h080;
    endsequence
    sequence s_sdo_take;
        sdo && tx_ready;
    endsequence
    AST_SDO_CMD: assert property (sdo |-> tx_dlc == 4'h8 && (cmd == 8'h2F ||
        cmd == 8'h2B || cmd == 8'h27 || cmd == 8'h23)) else $error("bad request command");
    AST_SDO_CLOSED: assert property (sdo |-> !sync_window)
        else $error("request inside window");
    AST_SDO_NODE: assert property (sdo |-> tx_id[6:0] != 7'h00)
        else $error("request id without node");
    AST_SYNC_FRAME: assert property (tx_valid && tx_id == 11'h080 |->
        tx_dlc == 4'h0 || (tx_dlc == 4'h1 && cmd != 8'h00)) else $error("bad sync frame");
    AST_SYNC_ONCE: assert property (s_sync_take |=> !(tx_valid && tx_id == 11'h080))
        else $error("sync repeated");
    AST_WIN_OPEN: assert property ($rose(sync_window) |-> $past(tx_valid && tx_ready))
        else $error("window without sync");
    AST_SDO_ONE: assert property (s_sdo_take |=> (!sdo)[*3])
        else $error("request before answer");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)
        && $stable(tx_dlc) && $stable(tx_data)) else $error("offer changed");
    AST_RD_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside slot");
endmodule // cosdo_master_asserts
bind cosdo_master cosdo_master_asserts u_chk (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_valid,
    .tx_ready, .tx_id, .tx_dlc, .tx_data, .rx_valid, .rx_id, .rx_data, .sync_window
);
`default_nettype wire

// >>> dv/cosdo_dev_model.sv
// Behavioural drive-side device taking sync, answering service data and raising emergencies
`timescale 1ns/1ps
`default_nettype none
module cosdo_dev_model #(
    parameter [31:0] ABORT_CODE = 32'h0601_0002,
    parameter [15:0] EMCY_CODE  = 16'h1000,
    parameter [7:0]  PDO_START  = 8'h02,
    parameter        ERR_STOP   = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Link
    input  wire logic        tx_valid,
    output var  logic        tx_ready,
    input  wire logic [10:0] tx_id,
    input  wire logic [3:0]  tx_dlc,
    input  wire logic [63:0] tx_data,
    output var  logic        rx_valid,
    output var  logic [10:0] rx_id,
    output var  logic [63:0] rx_data,
    // Bench controls and capture
    input  wire logic        slow,
    input  wire logic        refuse,
    input  wire logic        emcy_go,
    input  wire logic [7:0]  emcy_num,
    input  wire logic [6:0]  node,
    output var  logic [10:0] cap_id,
    output var  logic [3:0]  cap_dlc,
    output var  logic [63:0] cap_data,
    output var  logic [7:0]  frame_cnt
);
    logic [4:0]  wait_ff;
    logic [5:0]  due_ff;
    logic [63:0] rsp_ff;
    logic [31:0] hist_ff, obj_ff;
    logic [7:0]  ereg_ff, cnt_ff;
    logic        pend_ff, stop_ff, armed_ff;
    logic [7:0]  cmd;
    logic        ok;
    assign cmd = tx_data[63:56];
    assign ok  = cmd == 8'h2F || cmd == 8'h2B || cmd == 8'h27 || cmd == 8'h23;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_ready  <= 1'b0;
            rx_valid  <= 1'b0;
            rx_id     <= 11'h000;
            rx_data   <= 64'h0;
            frame_cnt <= 8'h00;
            wait_ff   <= 5'h00;
            pend_ff   <= 1'b0;
            stop_ff   <= 1'b0;
            armed_ff  <= 1'b0;
            ereg_ff   <= 8'h00;
            cnt_ff    <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            rx_id    <= ~rx_id;
            rx_data  <= ~rx_data;
            if (tx_valid && tx_ready) begin
                tx_ready  <= 1'b0;
                wait_ff   <= 5'h00;
                cap_id    <= tx_id;
                cap_dlc   <= tx_dlc;
                cap_data  <= tx_data;
                frame_cnt <= frame_cnt + 8'h01;
                if (tx_id == 11'h080) begin
                    cnt_ff   <= cnt_ff + 8'h01;
                    armed_ff <= armed_ff | (tx_dlc == 4'h1 && cmd == PDO_START);
                end
                if (tx_id[10:7] == 4'hC && !stop_ff) begin
                    pend_ff <= 1'b1;
                    due_ff  <= slow ? 6'h20 : 6'h03;
                    obj_ff  <= {tx_data[7:0], tx_data[15:8], tx_data[23:16], tx_data[31:24]};
                    rsp_ff  <= (ok && !refuse) ? {8'h60, tx_data[55:32], 32'h0} :
                        {8'h80, tx_data[55:32], ABORT_CODE[7:0], ABORT_CODE[15:8],
                        ABORT_CODE[23:16], ABORT_CODE[31:24]};
                end
            end else if (tx_valid) begin
                wait_ff  <= wait_ff + 5'h01;
                tx_ready <= wait_ff >= (slow ? 5'h07 : 5'h00);
            end
            if (emcy_go) begin
                ereg_ff  <= ereg_ff | 8'h01;
                hist_ff  <= {EMCY_CODE, ereg_ff | 8'h01, emcy_num};
                stop_ff  <= ERR_STOP;
                rx_valid <= 1'b1;
                rx_id    <= 11'h080 + {4'h0, node};
                rx_data  <= {16'h0, ereg_ff | 8'h01, emcy_num, 32'h0};
            end else if (pend_ff) begin
                due_ff <= due_ff - 6'h01;
                if (due_ff == 6'h00) begin
                    pend_ff  <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_id    <= 11'h580 + {4'h0, node};
                    rx_data  <= rsp_ff;
                end
            end
        end
    end
endmodule // cosdo_dev_model
`default_nettype wire

// >>> dv/cosdo_master_test.sv
// Self-checking bench for the master-side controller
`timescale 1ns/1ps
`default_nettype none
`include "cosdo_map.vh"
module cosdo_master_test;
    logic        ref_clk, reset_n, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, sync_window;
    logic        slow, refuse, emcy_go;
    logic [3:0]  reg_addr, tx_dlc, cap_dlc;
    logic [31:0] reg_wdata, reg_rdata;
    logic [10:0] tx_id, rx_id, cap_id;
    logic [63:0] tx_data, rx_data, cap_data;
    logic [7:0]  emcy_num, frame_cnt;
    int          num_errors, checked, cycles;
    cosdo_master DUT (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .rx_valid, .rx_id,
        .rx_data, .sync_window);
    cosdo_dev_model u_dev (.ref_clk, .reset_n, .tx_valid, .tx_ready, .tx_id, .tx_dlc,
        .tx_data, .rx_valid, .rx_id, .rx_data, .slow, .refuse, .emcy_go, .emcy_num,
        .node(7'h05), .cap_id, .cap_dlc, .cap_data, .frame_cnt);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic complete_run;
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run;
        end
    end
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask
    task automatic wait_idle(output logic [31:0] s);
        for (int k = 0; k < 200; k++) begin
            rd(`COSDO_REG_STATUS, s);
            if (s[2] === 1'b0) return;
        end
        chk("busy", 0, 1);
    endtask
    task automatic download(input logic [23:0] ix, input logic [31:0] d, input int l);
        wr(`COSDO_REG_SDOIDX, {8'h00, ix});
        wr(`COSDO_REG_SDODATA, d);
        wr(`COSDO_REG_SDOLEN, l);
        wr(`COSDO_REG_CTRL, 32'h6);
    endtask
    task automatic t_reset;
        rchk("node", `COSDO_REG_NODE, 32'h1);
        rchk("window", `COSDO_REG_WIN, 32'h0);
        rchk("overflow", `COSDO_REG_OVF, 32'h0);
        rchk("status", `COSDO_REG_STATUS, 32'h0);
        rchk("unmapped", 4'hF, 32'h0);
    endtask
    task automatic t_sync_counter;
        logic [7:0] f;
        wr(`COSDO_REG_OVF, 32'h3);
        for (int i = 0; i < 5; i++) begin
            f = frame_cnt;
            if (i == 4) wr(`COSDO_REG_OVF, 32'h1);
            wr(`COSDO_REG_CTRL, 32'hD);
            repeat (6) @(posedge ref_clk);
            chk("sync id", {11'h080, f + 8'h01}, {cap_id, frame_cnt});
            if (i < 4) chk("sync count", {4'h1, 8'(1 + i % 3)}, {cap_dlc, cap_data[63:56]});
            else chk("sync plain", 4'h0, cap_dlc);
        end
    endtask
    task automatic t_sync_window;
        int n;
        n = 0;
        wr(`COSDO_REG_WIN, 32'h3);
        wr(`COSDO_REG_CTRL, 32'h5);
        for (int k = 0; k < 20 && !sync_window; k++) @(negedge ref_clk);
        while (sync_window && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk("window length", 1, n >= 50 && n <= 76);
        @(posedge ref_clk);
    endtask
    task automatic t_sdo_lengths;
        logic [7:0]  cmds [4] = '{8'h2F, 8'h2B, 8'h27, 8'h23};
        logic [31:0] m, s;
        wr(`COSDO_REG_NODE, 32'h5);
        for (int l = 1; l <= 4; l++) begin
            m = 32'hFFFFFFFF << (8 * (4 - l));
            download({8'h10 + l[7:0], 16'h607A}, 32'hA1B2C3D4, l);
            wait_idle(s);
            chk("request id", 11'h605, cap_id);
            chk("request head", {cmds[l-1], 16'h7A60, 8'h10 + l[7:0]}, cap_data[63:32]);
            chk("request data", 32'hD4C3B2A1 & m, cap_data[31:0] & m);
            chk("done", 2'b01, {s[4], s[3]});
        end
    endtask
    task automatic t_sdo_abort;
        logic [31:0] s;
        refuse <= 1'b1;
        download(24'h00_6040, 32'h0000_000F, 2);
        wait_idle(s);
        chk("abort flag", 2'b10, {s[4], s[3]});
        rchk("abort code", `COSDO_REG_ABORT, 32'h0601_0002);
        refuse <= 1'b0;
    endtask
    task automatic t_len_bad;
        logic [7:0]  f;
        logic [31:0] s;
        f = frame_cnt;
        download(24'h00_6060, 32'h1, 0);
        repeat (30) @(posedge ref_clk);
        rd(`COSDO_REG_STATUS, s);
        chk("bad length", {f, 1'b1}, {frame_cnt, s[6]});
    endtask
    task automatic t_sdo_in_window;
        logic [31:0] s;
        slow <= 1'b1;
        wr(`COSDO_REG_WIN, 32'h2);
        wr(`COSDO_REG_CTRL, 32'h5);
        download(24'h01_1600, 32'h1234_5678, 4);
        wait_idle(s);
        chk("late request", {11'h605, 2'b01}, {cap_id, s[4], s[3]});
        slow <= 1'b0;
    endtask
    task automatic t_emcy;
        logic [31:0] s;
        emcy_num <= 8'h42;
        emcy_go <= 1'b1;
        @(posedge ref_clk);
        emcy_go <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(`COSDO_REG_STATUS, s);
        chk("emergency seen", 1, s[7]);
        rchk("emergency", `COSDO_REG_EMCY, {8'h85, 16'h0000, 8'h01});
        rd(`COSDO_REG_STATUS, s);
        chk("emergency clear", 0, s[7]);
    endtask
    initial begin
        reset_n = 1'b0;
        {reg_wr, reg_rd, slow, refuse, emcy_go} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        emcy_num = 8'h00;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_reset;
        t_sync_counter;
        t_sync_window;
        t_sdo_lengths;
        t_sdo_abort;
        t_len_bad;
        t_sdo_in_window;
        t_emcy;
        complete_run;
    end
endmodule // cosdo_master_test
`default_nettype wire
